// ===== pmas_pkg.sv
// Package for the power monitor converter setup block
package pmas_pkg;
	// Register addresses
	localparam logic [5:0]  PMAS_ADDR_SETUP = 6'h01;
	localparam logic [5:0]  PMAS_ADDR_SCALE = 6'h02;
	// Reset values
	localparam logic [15:0] PMAS_SETUP_RST = 16'hFB68;
	localparam logic [14:0] PMAS_SCALE_RST = 15'h1000;
	// Field positions in the setup register
	localparam int PMAS_MODE_LSB = 12;
	localparam int PMAS_BCT_LSB  = 9;
	localparam int PMAS_SCT_LSB  = 6;
	localparam int PMAS_TCT_LSB  = 3;
	localparam int PMAS_AVG_LSB  = 0;
	// Clock rate and conversion times
	localparam int PMAS_CLK_MHZ = 100;
	localparam int PMAS_CT_US0 = 50;
	localparam int PMAS_CT_US1 = 84;
	localparam int PMAS_CT_US2 = 150;
	localparam int PMAS_CT_US3 = 280;
	localparam int PMAS_CT_US4 = 540;
	localparam int PMAS_CT_US5 = 1052;
	localparam int PMAS_CT_US6 = 2074;
	localparam int PMAS_CT_US7 = 4120;
	localparam int PMAS_US_CYC = PMAS_CLK_MHZ;
	// Averaging counts per code
	localparam int PMAS_AVG_N0 = 1;
	localparam int PMAS_AVG_N1 = 4;
	localparam int PMAS_AVG_N2 = 16;
	localparam int PMAS_AVG_N3 = 64;
	localparam int PMAS_AVG_N4 = 128;
	localparam int PMAS_AVG_N5 = 256;
	localparam int PMAS_AVG_N6 = 512;
	localparam int PMAS_AVG_N7 = 1024;
	// Register access request, read or write
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [5:0]  addr;
		logic [15:0] wdata;
	} pmas_req_s;
	// Channel indices in sequencing order
	typedef enum logic [1:0] {PMAS_CH_BUS, PMAS_CH_SENSE, PMAS_CH_TEMP} pmas_ch_e;
endpackage

// ===== pmas_setup.sv
// Converter setup registers and conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module pmas_setup
	import pmas_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_sys_rst,
	input  wire pmas_req_s   i_req,
	output logic      [15:0] o_rdata,
	output logic      [14:0] o_scale,
	output logic             o_busy,
	output logic      [1:0]  o_conv_ch,
	output logic             o_sample_stb,
	output logic             o_publish,
	output logic      [1:0]  o_publish_ch,
	output logic             o_set_done
);
	// Cycles for a conversion time code
	function automatic logic [18:0] ct_cycles(input logic [2:0] code);
		int us;
		unique case (code)
			3'd0: us = PMAS_CT_US0;
			3'd1: us = PMAS_CT_US1;
			3'd2: us = PMAS_CT_US2;
			3'd3: us = PMAS_CT_US3;
			3'd4: us = PMAS_CT_US4;
			3'd5: us = PMAS_CT_US5;
			3'd6: us = PMAS_CT_US6;
			3'd7: us = PMAS_CT_US7;
		endcase
		return 19'(us * PMAS_US_CYC);
	endfunction

	// Sample count for an averaging code
	function automatic logic [10:0] avg_n(input logic [2:0] code);
		int n;
		unique case (code)
			3'd0: n = PMAS_AVG_N0;
			3'd1: n = PMAS_AVG_N1;
			3'd2: n = PMAS_AVG_N2;
			3'd3: n = PMAS_AVG_N3;
			3'd4: n = PMAS_AVG_N4;
			3'd5: n = PMAS_AVG_N5;
			3'd6: n = PMAS_AVG_N6;
			3'd7: n = PMAS_AVG_N7;
		endcase
		return 11'(n);
	endfunction

	typedef enum logic [1:0] {S_IDLE, S_CONV, S_NEXT} pmas_state_e;

	logic [15:0] setup_q;
	logic [14:0] scale_q;
	pmas_state_e state_q;
	logic [1:0]  ch_q;
	logic [18:0] tick_q;
	logic [10:0] samp_q;
	logic        arm_q;
	logic        pub_q;
	logic        done_q;
	logic [1:0]  pch_q;

	// Field decode
	wire logic [3:0] mode_w  = setup_q[PMAS_MODE_LSB +: 4];
	wire logic [2:0] en_w    = mode_w[2:0];
	wire logic       cont_w  = mode_w[3];
	wire logic       shut_w  = (en_w == 3'd0);
	wire logic [2:0] avg_w   = setup_q[PMAS_AVG_LSB +: 3];
	wire logic [2:0] ctc_w   = (ch_q == 2'(PMAS_CH_BUS))   ? setup_q[PMAS_BCT_LSB +: 3] :
	                           (ch_q == 2'(PMAS_CH_SENSE)) ? setup_q[PMAS_SCT_LSB +: 3] :
	                                                         setup_q[PMAS_TCT_LSB +: 3];
	wire logic [18:0] ct_w   = ct_cycles(ctc_w);
	wire logic [10:0] navg_w = avg_n(avg_w);
	wire logic       tick_end_w = (tick_q == ct_w - 19'd1);
	wire logic       run_end_w  = tick_end_w && (samp_q == navg_w - 11'd1);
	wire logic       wr_setup_w = i_req.wr && (i_req.addr == PMAS_ADDR_SETUP);
	wire logic       wr_scale_w = i_req.wr && (i_req.addr == PMAS_ADDR_SCALE);

	// First enabled channel at or after a given index, fixed order
	function automatic logic [2:0] next_ch(input logic [2:0] en, input logic [1:0] from);
		logic [2:0] r;
		r = 3'b100;
		for (int i = 2; i >= 0; i--)
		begin
			if (en[i] && (2'(i) >= from))
				r = {1'b0, 2'(i)};
		end
		return r;
	endfunction

	wire logic [2:0] first_w = next_ch(en_w, 2'd0);
	wire logic [2:0] after_w = (ch_q == 2'd2) ? 3'b100 : next_ch(en_w, ch_q + 2'd1);

	// Register writes; a setup write also arms a single shot
	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			setup_q <= PMAS_SETUP_RST;
			scale_q <= PMAS_SCALE_RST;
		end
		else
		begin
			if (wr_setup_w)
				setup_q <= i_req.wdata;
			if (wr_scale_w)
				scale_q <= i_req.wdata[14:0];
		end
	end

	// Sequencer; a setup write restarts from idle so new fields take effect cleanly
	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			state_q <= S_IDLE;
			ch_q    <= 2'd0;
			tick_q  <= 19'd0;
			samp_q  <= 11'd0;
			arm_q   <= 1'b0;
			pub_q   <= 1'b0;
			done_q  <= 1'b0;
			pch_q   <= 2'd0;
		end
		else
		begin
			pub_q  <= 1'b0;
			done_q <= 1'b0;
			if (wr_setup_w)
			begin
				state_q <= S_IDLE;
				arm_q   <= 1'b1;
			end
			else
			begin
				unique case (state_q)
					S_IDLE:
					begin
						if (!shut_w && (cont_w || arm_q))
						begin
							arm_q   <= 1'b0;
							ch_q    <= first_w[1:0];
							tick_q  <= 19'd0;
							samp_q  <= 11'd0;
							state_q <= S_CONV;
						end
					end
					S_CONV:
					begin
						tick_q <= tick_end_w ? 19'd0 : tick_q + 19'd1;
						if (tick_end_w)
							samp_q <= samp_q + 11'd1;
						if (run_end_w)
						begin
							pub_q   <= 1'b1;
							pch_q   <= ch_q;
							state_q <= S_NEXT;
						end
					end
					S_NEXT:
					begin
						samp_q <= 11'd0;
						if (after_w[2])
						begin
							done_q  <= 1'b1;
							state_q <= S_IDLE;
						end
						else
						begin
							ch_q    <= after_w[1:0];
							state_q <= S_CONV;
						end
					end
				endcase
			end
		end
	end

	// Read data; scale bit 15 reads zero, unmapped reads zero
	always_ff @(posedge i_core_clk)
	begin
		if (i_sys_rst)
			o_rdata <= 16'h0000;
		else if (i_req.rd)
			o_rdata <= (i_req.addr == PMAS_ADDR_SETUP) ? setup_q :
			           (i_req.addr == PMAS_ADDR_SCALE) ? {1'b0, scale_q} : 16'h0000;
	end

	// Outputs; scale drives the current math and its weight
	assign o_scale      = scale_q;
	assign o_busy       = (state_q != S_IDLE);
	assign o_conv_ch    = ch_q;
	assign o_sample_stb = (state_q == S_CONV) && tick_end_w;
	assign o_publish    = pub_q;
	assign o_publish_ch = pch_q;
	assign o_set_done   = done_q;

	// Checks
	property p_shut_idle;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(shut_w && state_q == S_IDLE && !wr_setup_w) |=> (state_q == S_IDLE);
	endproperty
	a_shut_idle: assert property (p_shut_idle) else $error("conversion in shutdown");

	property p_single_stop;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(o_set_done && !cont_w && !arm_q && !wr_setup_w) |=> (state_q == S_IDLE);
	endproperty
	a_single_stop: assert property (p_single_stop) else $error("single shot did not stop");

	property p_cont_restart;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(o_set_done && cont_w && !shut_w && !wr_setup_w) |=> (state_q == S_CONV);
	endproperty
	a_cont_restart: assert property (p_cont_restart) else $error("continuous did not restart");

	property p_reset_val;
		@(posedge i_core_clk) $fell(i_sys_rst) |-> (setup_q == 16'hFB68 && scale_q == 15'h1000);
	endproperty
	a_reset_val: assert property (p_reset_val) else $error("bad reset values");

	property p_ch_enabled;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(state_q == S_CONV) |-> en_w[ch_q];
	endproperty
	a_ch_enabled: assert property (p_ch_enabled) else $error("disabled channel converted");

	property p_pub_run;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		o_publish |-> ($past(samp_q) == navg_w - 11'd1);
	endproperty
	a_pub_run: assert property (p_pub_run) else $error("publish before averaging done");

	property p_ct_bus;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(setup_q[11:9] == 3'd0 && ch_q == 2'd0) |-> (ct_w == 19'd5000);
	endproperty
	a_ct_bus: assert property (p_ct_bus) else $error("bus time wrong");

	property p_rsv_zero;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_req.rd && i_req.addr == PMAS_ADDR_SCALE) |=> (o_rdata[15] == 1'b0 && o_rdata[14:0] == $past(scale_q));
	endproperty
	a_rsv_zero: assert property (p_rsv_zero) else $error("scale readback wrong");

	property p_avg_map;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(avg_w == 3'd7) |-> (navg_w == 11'd1024);
	endproperty
	a_avg_map: assert property (p_avg_map) else $error("average count wrong");

	c_done: cover property (@(posedge i_core_clk) o_set_done);
	c_pub_temp: cover property (@(posedge i_core_clk) o_publish && o_publish_ch == 2'd2);
	c_write: cover property (@(posedge i_core_clk) wr_setup_w ##1 o_busy);
endmodule
`default_nettype wire

// ===== pmas_host.sv
// Host controller model issuing register accesses to the setup block
`timescale 1ns/1ns
`default_nettype none
module pmas_host
	import pmas_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic [15:0] i_rdata,
	output var  pmas_req_s   o_req
);
	// Idle request from time zero
	initial o_req = '0;
	// One-cycle write strobe, dropped after the taking edge
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge i_core_clk);
		o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_core_clk);
		o_req <= '0;
	endtask
	// Read strobe; data is settled just after the taking edge
	task automatic rd(input logic [5:0] a, output logic [15:0] d);
		@(posedge i_core_clk);
		o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge i_core_clk);
		o_req <= '0;
		#1 d = i_rdata;
	endtask
endmodule
`default_nettype wire

// ===== pmas_setup_tb.sv
// Self-checking bench for the converter setup block
`timescale 1ns/1ns
`default_nettype none
module pmas_setup_tb
	import pmas_pkg::*;
;
	typedef struct packed {
		logic [5:0]  addr;
		logic [15:0] wdata;
		logic [15:0] exp;
		logic        idle;
	} pmas_row_s;
	// Writes with their read-back and whether the sequencer must stop
	localparam pmas_row_s ROWS [7] = '{
		'{6'h02, 16'hFFFF, 16'h7FFF, 1'b0},
		'{6'h02, 16'h8001, 16'h0001, 1'b0},
		'{6'h02, 16'h1234, 16'h1234, 1'b0},
		'{6'h01, 16'hA5A5, 16'hA5A5, 1'b0},
		'{6'h01, 16'h8000, 16'h8000, 1'b1},
		'{6'h03, 16'h5555, 16'h0000, 1'b0},
		'{6'h01, 16'h0000, 16'h0000, 1'b1}
	};
	logic        core_clk = 1'b0;
	logic        sys_rst  = 1'b1;
	pmas_req_s   req;
	logic [15:0] rdata;
	logic [14:0] scale;
	logic        busy;
	logic        stb;
	logic        pub;
	logic        done;
	logic [1:0]  pub_ch;
	logic [1:0]  conv_ch;
	int          bad_count  = 0;
	int          n_compared = 0;
	int          n_stb      = 0;
	int          k;
	int          nch;
	logic [1:0]  pubq[$];
	logic [1:0]  stbq[$];
	logic [15:0] rd_v;

	pmas_host host (.i_core_clk(core_clk), .i_rdata(rdata), .o_req(req));
	pmas_setup uut (.i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_req(req),
		.o_rdata(rdata), .o_scale(scale), .o_busy(busy), .o_conv_ch(conv_ch),
		.o_sample_stb(stb), .o_publish(pub), .o_publish_ch(pub_ch), .o_set_done(done));

	// Free-running 100 MHz clock
	initial
	begin
		forever #5 core_clk = ~core_clk;
	end
	// Sample pulses, the channel each one ends, and published channels
	always @(posedge core_clk)
	begin
		if (stb === 1'b1)
		begin
			n_stb++;
			stbq.push_back(conv_ch);
		end
		if (pub === 1'b1)
			pubq.push_back(pub_ch);
	end

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Bounded wait for the set-complete pulse; a hang ends the run
	task automatic wait_done(input int lim, output int n);
		n = 0;
		do
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		while (done !== 1'b1 && n < lim);
		if (done !== 1'b1)
		begin
			bad_count++;
			$display("mismatch %0t set never finished", $time);
			wrap_up();
		end
	endtask
	task automatic clear();
		n_stb = 0;
		pubq.delete();
		stbq.delete();
	endtask

	initial
	begin
		// Reset is sampled high at sixteen edges, released on the sixteenth
		repeat (15) @(posedge core_clk);
		#1;
		chk({1'b0, scale}, 16'h1000);
		chk({15'h0000, busy}, 16'h0000);
		@(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
		chk({15'h0000, busy}, 16'h0001);
		host.rd(PMAS_ADDR_SETUP, rd_v);
		chk(rd_v, 16'hFB68);
		host.rd(PMAS_ADDR_SCALE, rd_v);
		chk(rd_v, 16'h1000);
		// Ordinary register rows, read back at once
		foreach (ROWS[i])
		begin
			host.wr(ROWS[i].addr, ROWS[i].wdata);
			host.rd(ROWS[i].addr, rd_v);
			chk(rd_v, ROWS[i].exp);
			if (ROWS[i].addr == PMAS_ADDR_SCALE) chk({1'b0, scale}, ROWS[i].exp);
			repeat (3) @(posedge core_clk);
			#1;
			if (ROWS[i].idle) chk({15'h0000, busy}, 16'h0000);
		end
		// Every single-shot mix, shortest conversion time, no averaging
		for (int m = 1; m < 8; m++)
		begin
			clear();
			nch = $countones(m[2:0]);
			host.wr(PMAS_ADDR_SETUP, {4'(m), 12'h000});
			wait_done(nch * 5000 + 40, k);
			chk(16'(k >= nch * 5000 && k <= nch * 5000 + 8 * nch), 16'h0001);
			chk(16'(n_stb), 16'(nch));
			chk(16'(pubq.size()), 16'(nch));
			for (int b = 0; b < 3; b++)
				if (m[b] && pubq.size() > 0) chk(16'(pubq.pop_front()), 16'(b));
			for (int b = 0; b < 3; b++)
				if (m[b] && stbq.size() > 0) chk(16'(stbq.pop_front()), 16'(b));
			repeat (3) @(posedge core_clk);
			#1;
			chk({15'h0000, busy}, 16'h0000);
		end
		// Continuous bus-only runs two sets without another write
		clear();
		host.wr(PMAS_ADDR_SETUP, 16'h9000);
		wait_done(5040, k);
		wait_done(5040, k);
		// Sequencer passes through idle for one cycle before the next set
		@(posedge core_clk);
		#1;
		chk({15'h0000, busy}, 16'h0001);
		chk(16'(pubq.size()), 16'h0002);
		// Four-sample averaging publishes once at the end
		clear();
		host.wr(PMAS_ADDR_SETUP, 16'h1001);
		wait_done(20040, k);
		chk(16'(k >= 20000), 16'h0001);
		chk(16'(n_stb), 16'h0004);
		chk(16'(pubq.size()), 16'h0001);
		wrap_up();
	end
endmodule
`default_nettype wire
